// ### verilog/wgsf_top.sv
`include "wgsf_regs.svh"
// What this block does
// - Write gate input and qualified output polarities are each configurable.
// - Decoder control write disable bit blocks the qualified gate.
// - Masked index and coarse position must equal their targets to pass.
// - Burst sequencer write disable blocks the qualified gate.
// - Missing timing mark latch blocks the qualified gate.
// - Latched shock event blocks the qualified gate.
// - Arm write or read fault latch blocks the qualified gate.
// - Per-safety mask bits remove a condition from qualification.
// - Optional servo sector gating suppresses writes in servo sectors.
// - Shock input digital or analog; digital level programmable.
// - Shock events latched; raw shock goes to interrupt logic.
// - Fault pin outputs fault, or is input ORed into select A.
// - Drive fault when a safety blocks the gate or read fault latched.
// - Each drive fault cause can be masked individually.
// - Headerless mode faults on missing timing mark during reads too.
// - Arm error is returned gate as is; XOR mismatch means error.
// - XOR disabled: polarity-adjusted arm error input is the error.
// - Nonzero blank count ignores errors for that many clocks after edges.
// - Error while gate active sets arm write fault latch.
// - Error while gate inactive sets arm read fault latch.
// - Timing mark latch set and cleared by sequencer; clear wins.
// - All logic runs on the decode clock.
module wgsf_top #(
	parameter int BLANK_W = 4,
	parameter int POS_W   = 16
) (
	input  wire logic             MCLK,
	input  wire logic             SRST,
	input  wire logic             CE,
	input  wire logic             PSEL,
	input  wire logic             PENABLE,
	input  wire logic             PWRITE,
	input  wire logic [11:0]      PADDR,
	input  wire logic [31:0]      PWDATA,
	output logic                  PREADY,
	output logic [31:0]           PRDATA,
	output logic                  PSLVERR,
	input  wire logic             WRITE_GATE,
	input  wire logic             SHOCK_SENSE_INPUT,
	input  wire logic             SHOCK_ANALOG_CMP,
	input  wire logic             ARM_ERROR_INPUT,
	input  wire logic             SERVO_SECTOR,
	input  wire logic             BSQ_WRITE_DISABLE,
	input  wire logic             BSQ_SET_MISSING_MARK,
	input  wire logic             BSQ_CLR_MISSING_MARK,
	input  wire logic             BSQ_SELECT_A,
	input  wire logic [POS_W-1:0] HEADER_SHIFT,
	input  wire logic [POS_W-1:0] COARSE_POSITION_SHIFT,
	output logic                  QUALIFIED_WRITE_GATE,
	output logic                  SHOCK_RAW,
	output logic                  SELECT_A_OUTPUT,
	input  wire logic             DRIVE_FAULT_PIN_IN,
	output logic                  DRIVE_FAULT_PIN_OUT,
	output logic                  DRIVE_FAULT_PIN_OE_N
);
	import wgsf_pkg::*;

	// ************************************************************
	// Registers
	// ************************************************************
	wgsf_reg_if rif ();
	wgsf_word_t decoder_control_reg;
	wgsf_word_t fault_config_reg;
	wgsf_word_t safety_mask_reg;
	logic [POS_W-1:0] idx_target;
	logic [POS_W-1:0] idx_mask;
	logic [POS_W-1:0] pos_target;
	logic [POS_W-1:0] pos_mask;
	logic             shock_latch;
	logic             arm_write_fault_latch;
	logic             arm_read_fault_latch;
	logic             missing_mark_latch;
	logic             drive_fault;
	logic [BLANK_W-1:0] blank_cnt;
	logic             qwg_active;

	wgsf_apb u_apb (
		.clk     (MCLK),
		.rst     (SRST),
		.ce      (CE),
		.psel    (PSEL),
		.penable (PENABLE),
		.pwrite  (PWRITE),
		.paddr   (PADDR),
		.pwdata  (PWDATA),
		.pready  (PREADY),
		.prdata  (PRDATA),
		.pslverr (PSLVERR),
		.rif     (rif.bus)
	);

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic masked_eq(input logic [POS_W-1:0] v,
		input logic [POS_W-1:0] t, input logic [POS_W-1:0] m);
		masked_eq = ((v ^ t) & m) == '0;
	endfunction : masked_eq

	function automatic logic wr_hit(input logic [11:0] off);
		wr_hit = rif.wr && (rif.addr == off);
	endfunction : wr_hit

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	logic [2:0] sync_q;
	wgsf_sync #(.W(3)) u_sync (
		.clk (MCLK),
		.rst (SRST),
		.ce  (CE),
		.d   ({ARM_ERROR_INPUT, SHOCK_SENSE_INPUT, WRITE_GATE}),
		.q   (sync_q)
	);

	// ************************************************************
	// Configuration decode
	// ************************************************************
	wire cfg_wg_neg   = fault_config_reg[`WGSF_CFG_WG_NEG];
	wire cfg_qwg_neg  = fault_config_reg[`WGSF_CFG_QWG_NEG];
	wire cfg_servo_sector_en  = fault_config_reg[`WGSF_CFG_SERVO_SECTOR_EN];
	wire cfg_shk_ana  = fault_config_reg[`WGSF_CFG_SHK_ANA];
	wire cfg_shk_neg  = fault_config_reg[`WGSF_CFG_SHK_NEG];
	wire cfg_df_out   = fault_config_reg[`WGSF_CFG_DF_OUT];
	wire cfg_hdrless  = fault_config_reg[`WGSF_CFG_HDRLESS];
	wire cfg_xor_dis  = fault_config_reg[`WGSF_CFG_XOR_DIS];
	wire cfg_ae_neg   = fault_config_reg[`WGSF_CFG_AE_NEG];
	wire [BLANK_W-1:0] cfg_blank = fault_config_reg[`WGSF_CFG_BLANK_LO +: BLANK_W];
	wire [6:0] msk_q  = safety_mask_reg[6:0];
	wire [6:0] msk_df = safety_mask_reg[`WGSF_MSK_DF_LO +: 7];

	// ************************************************************
	// Shock path
	// ************************************************************
	wire shock_now = cfg_shk_ana ? SHOCK_ANALOG_CMP : (sync_q[1] ^ cfg_shk_neg);
	assign SHOCK_RAW = shock_now;

	// ************************************************************
	// Write gate qualification
	// ************************************************************
	wire wg_req = sync_q[0] ^ cfg_wg_neg;
	wire pos_ok = masked_eq(HEADER_SHIFT, idx_target, idx_mask)
		& masked_eq(COARSE_POSITION_SHIFT, pos_target, pos_mask);
	wire [6:0] block_cause;
	assign block_cause[`WGSF_MSK_DEC] = decoder_control_reg[`WGSF_DEC_WR_DIS];
	assign block_cause[`WGSF_MSK_POS] = ~pos_ok;
	assign block_cause[`WGSF_MSK_BSQ] = BSQ_WRITE_DISABLE;
	assign block_cause[`WGSF_MSK_STM] = missing_mark_latch;
	assign block_cause[`WGSF_MSK_SHK] = shock_latch;
	assign block_cause[`WGSF_MSK_AEW] = arm_write_fault_latch;
	assign block_cause[`WGSF_MSK_AER] = arm_read_fault_latch;
	wire [6:0] live_block = block_cause & ~msk_q;
	wire servo_sector_block = cfg_servo_sector_en & SERVO_SECTOR;
	wire next_qwg = wg_req & ~(|live_block) & ~servo_sector_block;

	// ************************************************************
	// Arm electronics error detection
	// ************************************************************
	wire qwg_pin  = qwg_active ^ cfg_qwg_neg;
	wire qwg_edge = (next_qwg != qwg_active);
	wire ae_in    = sync_q[2] ^ cfg_ae_neg;
	// Healthy electronics echo the gate pin; an inverted echo is a fault
	wire ae_err   = cfg_xor_dis ? ae_in : (ae_in ^ qwg_pin);
	wire blanked  = (blank_cnt != '0);
	wire ae_hit   = ae_err & ~blanked;

	// ************************************************************
	// Drive fault
	// ************************************************************
	wire [6:0] df_cause = block_cause & ~msk_df;
	wire [6:0] df_block = live_block & ~msk_df;
	// A safety counts only where it really blocks a requested write
	wire df_write = (|df_block[5:0]) & wg_req;
	wire df_stm   = df_cause[`WGSF_MSK_STM] & cfg_hdrless;
	wire df_read  = df_cause[`WGSF_MSK_AER];
	wire next_df  = df_write | df_stm | df_read;

	assign QUALIFIED_WRITE_GATE = qwg_pin;
	assign DRIVE_FAULT_PIN_OUT  = drive_fault;
	assign DRIVE_FAULT_PIN_OE_N = ~cfg_df_out;
	assign SELECT_A_OUTPUT = BSQ_SELECT_A | (~cfg_df_out & DRIVE_FAULT_PIN_IN);

	wire clr_wr  = wr_hit(`WGSF_OFF_CLEAR);
	wire [3:0] clr_bits = clr_wr ? rif.wdata[3:0] : 4'h0;

	// ************************************************************
	// Gate and fault state
	// ************************************************************
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			qwg_active  <= 1'b0;
			drive_fault <= 1'b0;
		end else if (CE) begin
			qwg_active  <= next_qwg;
			drive_fault <= next_df;
		end
	end

	// Reloads with the gate change itself, so the synchroniser lag is covered
	always_ff @(posedge MCLK) begin
		if (SRST)
			blank_cnt <= '0;
		else if (CE) begin
			if (qwg_edge)
				blank_cnt <= cfg_blank;
			else if (blanked)
				blank_cnt <= blank_cnt - 1'b1;
		end
	end

	// ************************************************************
	// Fault latches: a set wins over a firmware clear in one cycle
	// ************************************************************
	always_ff @(posedge MCLK) begin
		if (SRST)
			shock_latch <= 1'b0;
		else if (CE)
			shock_latch <= shock_now | (shock_latch & ~clr_bits[`WGSF_ST_SHK]);
	end

	always_ff @(posedge MCLK) begin
		if (SRST)
			arm_write_fault_latch <= 1'b0;
		else if (CE)
			arm_write_fault_latch <= (ae_hit & qwg_active)
				| (arm_write_fault_latch & ~clr_bits[`WGSF_ST_AEW]);
	end

	always_ff @(posedge MCLK) begin
		if (SRST)
			arm_read_fault_latch <= 1'b0;
		else if (CE)
			arm_read_fault_latch <= (ae_hit & ~qwg_active)
				| (arm_read_fault_latch & ~clr_bits[`WGSF_ST_AER]);
	end

	// ************************************************************
	// Missing timing mark latch: sequencer clear, then set, then firmware
	// ************************************************************
	always_ff @(posedge MCLK) begin
		if (SRST)
			missing_mark_latch <= 1'b0;
		else if (CE) begin
			if (BSQ_CLR_MISSING_MARK)
				missing_mark_latch <= 1'b0;
			else if (BSQ_SET_MISSING_MARK | clr_bits[`WGSF_ST_STM])
				missing_mark_latch <= BSQ_SET_MISSING_MARK;
		end
	end

	// ************************************************************
	// Register writes
	// ************************************************************
	wire wr_decoder_control_reg  = wr_hit(`WGSF_OFF_DECODER_CONTROL_REG);
	wire wr_cfg     = wr_hit(`WGSF_OFF_CFG);
	wire wr_mask    = wr_hit(`WGSF_OFF_MASK);
	wire wr_idx_tgt = wr_hit(`WGSF_OFF_IDX_TGT);
	wire wr_idx_msk = wr_hit(`WGSF_OFF_IDX_MSK);
	wire wr_gry_tgt = wr_hit(`WGSF_OFF_GRY_TGT);
	wire wr_gry_msk = wr_hit(`WGSF_OFF_GRY_MSK);
	wire [POS_W-1:0] wr_pos = rif.wdata[POS_W-1:0];

	always_ff @(posedge MCLK) begin
		if (SRST)
			decoder_control_reg <= `WGSF_RST_DECODER_CONTROL_REG;
		else if (CE & wr_decoder_control_reg)
			decoder_control_reg <= rif.wdata;
	end

	always_ff @(posedge MCLK) begin
		if (SRST)
			fault_config_reg <= `WGSF_RST_CFG;
		else if (CE & wr_cfg)
			fault_config_reg <= rif.wdata;
	end

	always_ff @(posedge MCLK) begin
		if (SRST)
			safety_mask_reg <= `WGSF_RST_MASK;
		else if (CE & wr_mask)
			safety_mask_reg <= rif.wdata;
	end

	always_ff @(posedge MCLK) begin
		if (SRST)
			idx_target <= '0;
		else if (CE & wr_idx_tgt)
			idx_target <= wr_pos;
	end

	always_ff @(posedge MCLK) begin
		if (SRST)
			idx_mask <= '0;
		else if (CE & wr_idx_msk)
			idx_mask <= wr_pos;
	end

	always_ff @(posedge MCLK) begin
		if (SRST)
			pos_target <= '0;
		else if (CE & wr_gry_tgt)
			pos_target <= wr_pos;
	end

	always_ff @(posedge MCLK) begin
		if (SRST)
			pos_mask <= '0;
		else if (CE & wr_gry_msk)
			pos_mask <= wr_pos;
	end

	// ************************************************************
	// Read decode
	// ************************************************************
	wire [31:0] status_word = {
		25'h0,
		shock_now,
		drive_fault,
		qwg_active,
		missing_mark_latch,
		arm_read_fault_latch,
		arm_write_fault_latch,
		shock_latch
	};
	wire [31:0] pos_pad_it = {{(32-POS_W){1'b0}}, idx_target};
	wire [31:0] pos_pad_im = {{(32-POS_W){1'b0}}, idx_mask};
	wire [31:0] pos_pad_gt = {{(32-POS_W){1'b0}}, pos_target};
	wire [31:0] pos_pad_gm = {{(32-POS_W){1'b0}}, pos_mask};
	always_comb begin
		rif.hit   = 1'b1;
		rif.rdata = 32'h0000_0000;
		case (rif.addr)
			`WGSF_OFF_DECODER_CONTROL_REG:  rif.rdata = decoder_control_reg;
			`WGSF_OFF_CFG:     rif.rdata = fault_config_reg;
			`WGSF_OFF_MASK:    rif.rdata = safety_mask_reg;
			`WGSF_OFF_IDX_TGT: rif.rdata = pos_pad_it;
			`WGSF_OFF_IDX_MSK: rif.rdata = pos_pad_im;
			`WGSF_OFF_GRY_TGT: rif.rdata = pos_pad_gt;
			`WGSF_OFF_GRY_MSK: rif.rdata = pos_pad_gm;
			`WGSF_OFF_STATUS:  rif.rdata = status_word;
			`WGSF_OFF_CLEAR:   rif.rdata = 32'h0000_0000;
			default:           rif.hit   = 1'b0;
		endcase
	end
endmodule : wgsf_top

// ### verilog/wgsf_regs.svh
`ifndef WGSF_REGS_SVH
`define WGSF_REGS_SVH
// ************************************************************
// Register byte offsets
// ************************************************************
`define WGSF_OFF_DECODER_CONTROL_REG   12'h000
`define WGSF_OFF_CFG      12'h004
`define WGSF_OFF_MASK     12'h008
`define WGSF_OFF_IDX_TGT  12'h00c
`define WGSF_OFF_IDX_MSK  12'h010
`define WGSF_OFF_GRY_TGT  12'h014
`define WGSF_OFF_GRY_MSK  12'h018
`define WGSF_OFF_STATUS   12'h01c
`define WGSF_OFF_CLEAR    12'h020
// ************************************************************
// Field positions
// ************************************************************
`define WGSF_DEC_WR_DIS   0
`define WGSF_CFG_WG_NEG   0
`define WGSF_CFG_QWG_NEG  1
`define WGSF_CFG_SERVO_SECTOR_EN  2
`define WGSF_CFG_SHK_ANA  3
`define WGSF_CFG_SHK_NEG  4
`define WGSF_CFG_DF_OUT   5
`define WGSF_CFG_HDRLESS  6
`define WGSF_CFG_XOR_DIS  7
`define WGSF_CFG_AE_NEG   8
`define WGSF_CFG_BLANK_LO 12
`define WGSF_MSK_DEC      0
`define WGSF_MSK_POS      1
`define WGSF_MSK_BSQ      2
`define WGSF_MSK_STM      3
`define WGSF_MSK_SHK      4
`define WGSF_MSK_AEW      5
`define WGSF_MSK_AER      6
`define WGSF_MSK_DF_LO    8
`define WGSF_ST_SHK       0
`define WGSF_ST_AEW       1
`define WGSF_ST_AER       2
`define WGSF_ST_STM       3
`define WGSF_ST_QWG       4
`define WGSF_ST_DF        5
`define WGSF_ST_SHK_RAW   6
// ************************************************************
// Reset values
// ************************************************************
`define WGSF_RST_DECODER_CONTROL_REG   32'h0000_0001
`define WGSF_RST_CFG      32'h0000_0020
`define WGSF_RST_MASK     32'h0000_0000
`define WGSF_RST_WORD     32'h0000_0000
`endif

// ### verilog/wgsf_pkg.sv
package wgsf_pkg;
	typedef logic [31:0] wgsf_word_t;
	typedef logic [11:0] wgsf_addr_t;
	typedef logic [6:0]  wgsf_cause_t;
	typedef enum logic [1:0] {
		WGSF_IDLE   = 2'b00,
		WGSF_ACCESS = 2'b01
	} wgsf_apb_state_t;
endpackage : wgsf_pkg

// ### verilog/wgsf_reg_if.sv
interface wgsf_reg_if;
	import wgsf_pkg::*;
	logic        wr;
	logic        rd;
	wgsf_addr_t  addr;
	wgsf_word_t  wdata;
	wgsf_word_t  rdata;
	logic        hit;
	modport bus (output wr, output rd, output addr, output wdata, input rdata, input hit);
	modport regs (input wr, input rd, input addr, input wdata, output rdata, output hit);
endinterface : wgsf_reg_if

// ### verilog/wgsf_apb.sv
module wgsf_apb (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	wgsf_reg_if.bus          rif
);
	import wgsf_pkg::*;
	wgsf_apb_state_t state;
	wire take;
	// ************************************************************
	// Zero-wait slave: access phase completes in its first cycle
	// ************************************************************
	// An access phase that did not follow its own setup cycle is ignored
	assign take       = psel & penable & ce & (state == WGSF_ACCESS);
	assign pready     = psel & penable;
	assign rif.wr     = take & pwrite & rif.hit;
	assign rif.rd     = take & ~pwrite;
	assign rif.addr   = paddr;
	assign rif.wdata  = pwdata;
	assign prdata     = (psel & penable & ~pwrite & rif.hit) ? rif.rdata : 32'h0000_0000;
	assign pslverr    = psel & penable & ~rif.hit;
	always_ff @(posedge clk) begin
		if (rst)
			state <= WGSF_IDLE;
		else if (ce)
			state <= (psel & ~penable) ? WGSF_ACCESS : WGSF_IDLE;
	end
endmodule : wgsf_apb

// ### verilog/wgsf_sync.sv
module wgsf_sync #(
	parameter int W = 3
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output logic [W-1:0]      q
);
	logic [W-1:0] meta;
	// First stage feeds only the second
	always_ff @(posedge clk) begin
		if (rst) begin
			meta <= '0;
			q    <= '0;
		end else if (ce) begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : wgsf_sync

// ### tb/wgsf_arm_model.sv
// ********************************
// Arm electronics return path
// ********************************
module wgsf_arm_model (
	input  wire logic qwg,
	input  wire logic fault,
	output logic      arm_err
);
	timeunit 1ns;
	timeprecision 1ps;
	// Healthy head echoes the gate as is; a commanded fault returns it inverted
	assign arm_err = fault ? ~qwg : qwg;
endmodule : wgsf_arm_model

// ### tb/wgsf_monitor.sv
// ********************************
// Port checks
// ********************************
module wgsf_monitor (
	input wire logic        MCLK,
	input wire logic        SRST,
	input wire logic        CE,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic        PREADY,
	input wire logic [31:0] PRDATA,
	input wire logic        BSQ_SELECT_A,
	input wire logic        SELECT_A_OUTPUT,
	input wire logic        DRIVE_FAULT_PIN_IN,
	input wire logic        DRIVE_FAULT_PIN_OUT,
	input wire logic        DRIVE_FAULT_PIN_OE_N,
	input wire logic        QUALIFIED_WRITE_GATE
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (SRST);
	property p_ready;
		PREADY == (PSEL && PENABLE);
	endproperty
	a_ready: assert property (p_ready)
		else $error("pready not tied to access phase");
	property p_rdata;
		!(PSEL && PENABLE) |-> PRDATA == 32'h0;
	endproperty
	a_rdata: assert property (p_rdata)
		else $error("read data outside access phase");
	property p_select_a_output_or;
		BSQ_SELECT_A |-> SELECT_A_OUTPUT;
	endproperty
	a_select_a_output_or: assert property (p_select_a_output_or)
		else $error("select a output lost sequencer bit");
	property p_select_a_output_in;
		DRIVE_FAULT_PIN_OE_N && DRIVE_FAULT_PIN_IN |-> SELECT_A_OUTPUT;
	endproperty
	a_select_a_output_in: assert property (p_select_a_output_in)
		else $error("fault pin input not merged into select a");
	property p_select_a_output_out;
		!DRIVE_FAULT_PIN_OE_N && !BSQ_SELECT_A |-> !SELECT_A_OUTPUT;
	endproperty
	a_select_a_output_out: assert property (p_select_a_output_out)
		else $error("select a high with pin in output mode");
	property p_rst;
		disable iff (1'b0) SRST && CE |=> !DRIVE_FAULT_PIN_OUT && !DRIVE_FAULT_PIN_OE_N
			&& !QUALIFIED_WRITE_GATE;
	endproperty
	a_rst: assert property (p_rst)
		else $error("outputs not at reset state");
	property p_ce_hold;
		!CE |=> $stable(QUALIFIED_WRITE_GATE) && $stable(DRIVE_FAULT_PIN_OUT);
	endproperty
	a_ce_hold: assert property (p_ce_hold)
		else $error("outputs moved with clock enable low");
	property p_oe_hold;
		!(PSEL && PENABLE && PWRITE) |=> $stable(DRIVE_FAULT_PIN_OE_N);
	endproperty
	a_oe_hold: assert property (p_oe_hold)
		else $error("pin direction changed without a write");
endmodule : wgsf_monitor

// ### tb/wgsf_top_tb_top.sv
`include "wgsf_regs.svh"
// ********************************
// Testbench
// ********************************
module wgsf_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import wgsf_pkg::*;
	logic MCLK, SRST, CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, se, arm_fault;
	logic WRITE_GATE, SHOCK_SENSE_INPUT, SHOCK_ANALOG_CMP, ARM_ERROR_INPUT, SERVO_SECTOR;
	logic BSQ_WRITE_DISABLE, BSQ_SET_MISSING_MARK, BSQ_CLR_MISSING_MARK, BSQ_SELECT_A;
	logic QUALIFIED_WRITE_GATE, SHOCK_RAW, SELECT_A_OUTPUT;
	logic DRIVE_FAULT_PIN_IN, DRIVE_FAULT_PIN_OUT, DRIVE_FAULT_PIN_OE_N;
	wgsf_addr_t  PADDR;
	wgsf_word_t  PWDATA, PRDATA, rd;
	logic [15:0] HEADER_SHIFT, COARSE_POSITION_SHIFT;
	int          err_total, n_tests, cnt;
	wgsf_top i_wgsf_top (.*);
	wgsf_arm_model i_wgsf_arm_model (.qwg(QUALIFIED_WRITE_GATE), .fault(arm_fault),
		.arm_err(ARM_ERROR_INPUT));
	initial begin
		MCLK = 1'b0;
		forever #4 MCLK = ~MCLK;
	end
	task summarize;
		if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : summarize
	always @(posedge MCLK) begin
		cnt <= cnt + 1;
		if (cnt == 5000) begin
			err_total++;
			summarize();
		end
	end
	task cyc(input int n);
		repeat (n) @(posedge MCLK);
	endtask : cyc
	task chk(input wgsf_word_t g, input wgsf_word_t e);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task apb(input logic w, input wgsf_addr_t a, input wgsf_word_t d);
		@(posedge MCLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		do @(posedge MCLK); while (PREADY !== 1'b1);
		rd = PRDATA;
		se = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb
	task wr(input wgsf_addr_t a, input wgsf_word_t d);
		apb(1'b1, a, d);
	endtask : wr
	task rdc(input wgsf_addr_t a, input wgsf_word_t e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdc
	task pin(input logic [1:0] e);
		cyc(6);
		#1;
		chk({30'h0, QUALIFIED_WRITE_GATE, DRIVE_FAULT_PIN_OUT}, {30'h0, e});
		cyc(1);
	endtask : pin
	task qw(input logic e);
		cyc(6);
		#1;
		chk({31'h0, QUALIFIED_WRITE_GATE}, {31'h0, e});
		cyc(1);
	endtask : qw
	initial begin
		{PSEL, PENABLE, PWRITE, SHOCK_SENSE_INPUT, SHOCK_ANALOG_CMP, SERVO_SECTOR} = '0;
		{BSQ_WRITE_DISABLE, BSQ_SET_MISSING_MARK, BSQ_CLR_MISSING_MARK, BSQ_SELECT_A} = '0;
		{DRIVE_FAULT_PIN_IN, arm_fault, CE, SRST, WRITE_GATE} = 5'b00111;
		{PADDR, PWDATA, HEADER_SHIFT, COARSE_POSITION_SHIFT} = '0;
		cyc(5);
		SRST <= 1'b0;
		rdc(`WGSF_OFF_DECODER_CONTROL_REG, `WGSF_RST_DECODER_CONTROL_REG);
		rdc(`WGSF_OFF_CFG, `WGSF_RST_CFG);
		rdc(`WGSF_OFF_MASK, `WGSF_RST_MASK);
		apb(1'b0, 12'h040, 32'h0);
		chk({31'h0, se}, 32'h1);
		wr(`WGSF_OFF_CFG, 32'h8020);
		pin(2'b01);
		wr(`WGSF_OFF_DECODER_CONTROL_REG, 32'h0);
		pin(2'b10);
		rdc(`WGSF_OFF_STATUS, 32'h10);
		BSQ_WRITE_DISABLE <= 1'b1;
		pin(2'b01);
		wr(`WGSF_OFF_MASK, 32'h4);
		pin(2'b10);
		wr(`WGSF_OFF_MASK, 32'h400);
		pin(2'b00);
		wr(`WGSF_OFF_MASK, 32'h0);
		BSQ_WRITE_DISABLE <= 1'b0;
		wr(`WGSF_OFF_IDX_MSK, 32'h00ff);
		wr(`WGSF_OFF_IDX_TGT, 32'h0012);
		HEADER_SHIFT <= 16'h3412;
		pin(2'b10);
		HEADER_SHIFT <= 16'h3413;
		pin(2'b01);
		HEADER_SHIFT <= 16'h3412;
		wr(`WGSF_OFF_GRY_MSK, 32'h8000);
		COARSE_POSITION_SHIFT <= 16'h8000;
		pin(2'b01);
		wr(`WGSF_OFF_GRY_TGT, 32'h8000);
		pin(2'b10);
		wr(`WGSF_OFF_CFG, 32'h8024);
		SERVO_SECTOR <= 1'b1;
		qw(1'b0);
		SERVO_SECTOR <= 1'b0;
		qw(1'b1);
		BSQ_SET_MISSING_MARK <= 1'b1;
		cyc(1);
		BSQ_SET_MISSING_MARK <= 1'b0;
		pin(2'b01);
		rdc(`WGSF_OFF_STATUS, 32'h28);
		{BSQ_SET_MISSING_MARK, BSQ_CLR_MISSING_MARK} <= 2'b11;
		cyc(1);
		{BSQ_SET_MISSING_MARK, BSQ_CLR_MISSING_MARK} <= 2'b00;
		pin(2'b10);
		WRITE_GATE <= 1'b0;
		BSQ_SET_MISSING_MARK <= 1'b1;
		cyc(1);
		BSQ_SET_MISSING_MARK <= 1'b0;
		pin(2'b00);
		wr(`WGSF_OFF_CFG, 32'h8064);
		pin(2'b01);
		BSQ_CLR_MISSING_MARK <= 1'b1;
		cyc(1);
		BSQ_CLR_MISSING_MARK <= 1'b0;
		WRITE_GATE <= 1'b1;
		pin(2'b10);
		SHOCK_SENSE_INPUT <= 1'b1;
		cyc(4);
		#1;
		chk({31'h0, SHOCK_RAW}, 32'h1);
		cyc(1);
		SHOCK_SENSE_INPUT <= 1'b0;
		pin(2'b01);
		wr(`WGSF_OFF_CLEAR, 32'h1);
		pin(2'b10);
		wr(`WGSF_OFF_CFG, 32'h806c);
		SHOCK_SENSE_INPUT <= 1'b1;
		pin(2'b10);
		SHOCK_ANALOG_CMP <= 1'b1;
		cyc(1);
		SHOCK_ANALOG_CMP <= 1'b0;
		pin(2'b01);
		SHOCK_SENSE_INPUT <= 1'b0;
		wr(`WGSF_OFF_CLEAR, 32'h1);
		wr(`WGSF_OFF_CFG, 32'h8020);
		pin(2'b10);
		arm_fault <= 1'b1;
		pin(2'b01);
		cyc(8);
		rdc(`WGSF_OFF_STATUS, 32'h26);
		arm_fault <= 1'b0;
		wr(`WGSF_OFF_CLEAR, 32'h6);
		pin(2'b10);
		WRITE_GATE <= 1'b0;
		pin(2'b00);
		arm_fault <= 1'b1;
		pin(2'b01);
		rdc(`WGSF_OFF_STATUS, 32'h24);
		arm_fault <= 1'b0;
		wr(`WGSF_OFF_CLEAR, 32'h4);
		wr(`WGSF_OFF_CFG, 32'h80a0);
		cyc(6);
		rdc(`WGSF_OFF_STATUS, 32'h0);
		wr(`WGSF_OFF_CFG, 32'h81a0);
		cyc(6);
		rdc(`WGSF_OFF_STATUS, 32'h24);
		wr(`WGSF_OFF_MASK, 32'h6060);
		wr(`WGSF_OFF_CFG, 32'h8023);
		qw(1'b0);
		WRITE_GATE <= 1'b1;
		qw(1'b1);
		wr(`WGSF_OFF_CFG, 32'h8000);
		DRIVE_FAULT_PIN_IN <= 1'b1;
		cyc(2);
		chk({30'h0, DRIVE_FAULT_PIN_OE_N, SELECT_A_OUTPUT}, 32'h3);
		DRIVE_FAULT_PIN_IN <= 1'b0;
		BSQ_SELECT_A <= 1'b1;
		cyc(2);
		chk({31'h0, SELECT_A_OUTPUT}, 32'h1);
		CE <= 1'b0;
		wr(`WGSF_OFF_DECODER_CONTROL_REG, 32'h1);
		CE <= 1'b1;
		rdc(`WGSF_OFF_DECODER_CONTROL_REG, 32'h0);
		summarize();
	end
endmodule : wgsf_top_tb_top
bind wgsf_top wgsf_monitor i_wgsf_monitor (.*);
